// [pkg/phy_bist_map.svh]
// register offsets, field positions, reset values and counts of the self-test block
`ifndef PHY_BIST_MAP_SVH
`define PHY_BIST_MAP_SVH
// Function
// - a 16-bit receive error tally reads back, clears where ones are written, resets to zero.
// - generator enable field 15:12 runs the pattern generator at all ones and stops it at zero.
// - in reverse loopback bit 7 clear withholds received packets from the MAC, set forwards them.
// - bit 7 is accepted only while reverse loopback is the selected mode.
// - in MAC-side loopback bit 6 clear keeps transmit data off the medium, set also sends it.
// - bit 6 is accepted only while MAC-side (digital) loopback is the selected mode.
// - the one-hot select in 5:2 picks none, digital, analog, external or reverse loopback.
// - at 100 Mb/s the coding field loops before scrambler, after scrambler or after MLT3.
// - at 1 Gb/s a coding field with its low bit set loops before the gigabit signal path.
// - status bit 11 shows that the pattern checker is locked to the received bytes.
// - status bit 10 latches on checker sync loss and clears when the status is read.
// - status bit 9 is high while the pattern generator produces traffic.

// register word addresses
`define ADDR_RX_TALLY   5'h15
`define ADDR_LOOP_CTRL  5'h16
`define ADDR_GEN_STATUS 5'h17
`define ADDR_IRQ_STAT   5'h1c
`define ADDR_IRQ_MASK   5'h1d

// reset values and limits
`define TALLY_RESET     16'h0000
`define TALLY_MAX       16'hffff
`define TALLY_ONE       16'h0001
`define CTRL_RESET      16'h0000
`define STATUS_RESET    16'h0040
`define READ_IDLE       16'h0000

// field positions
`define GEN_EN_HI       15
`define GEN_EN_LO       12
`define GEN_EN_RUN      4'hf
`define RSVD_RW_HI      9
`define RSVD_RW_LO      8
`define FWD_RX_BIT      7
`define FWD_TX_BIT      6
`define LOOP_SEL_HI     5
`define LOOP_SEL_LO     2
`define PCS_HI          1
`define PCS_LO          0
`define LOCK_BIT        11
`define LOSS_BIT        10
`define BUSY_BIT        9

// interrupt bits and checker counts
`define IRQ_BITS        3
`define IRQ_SLIP        0
`define IRQ_GAIN        1
`define IRQ_SAT         2
`define LOCK_MATCHES    3'h4
`define PRBS_SEED       7'h7f
`endif

// [pkg/phy_bist_pkg.sv]
// types shared by the self-test and loopback control block
`default_nettype none
package phy_bist_pkg;
  // one-hot loopback select field
  typedef enum logic [3:0]
  {
    LOOP_NONE     = 4'h0,
    LOOP_DIGITAL  = 4'h1,
    LOOP_ANALOG   = 4'h2,
    LOOP_EXTERNAL = 4'h4,
    LOOP_REVERSE  = 4'h8
  } loop_sel_t;

  // resolved loop point told to the signal chain
  typedef enum logic [3:0]
  {
    LP_NONE      = 4'h0,
    LP_DIGITAL   = 4'h1,
    LP_ANALOG    = 4'h2,
    LP_EXTERNAL  = 4'h3,
    LP_REVERSE   = 4'h4,
    LP_PRE_SCR   = 4'h5,
    LP_POST_SCR  = 4'h6,
    LP_POST_MLT3 = 4'h7,
    LP_PRE_GDSP  = 4'h8
  } loop_point_t;

  // checker states, gray along off, hunt, lock
  typedef enum logic [1:0]
  {
    CHK_OFF  = 2'b00,
    CHK_HUNT = 2'b01,
    CHK_LOCK = 2'b11
  } chk_state_t;
endpackage : phy_bist_pkg
`default_nettype wire

// [logic/prbs_engine.sv]
// byte-wide pseudo-random pattern generator and self-synchronising checker
`include "phy_bist_map.svh"
`default_nettype none
module prbs_engine
(
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       gen_run,
  output var  logic [7:0] gen_byte,
  output var  logic       gen_busy,
  input  wire logic       chk_en,
  input  wire logic       chk_valid,
  input  wire logic [7:0] chk_data,
  output var  logic       chk_locked,
  output var  logic       chk_slip,
  output var  logic       chk_gain
);
  import phy_bist_pkg::*;

  chk_state_t state_q;
  logic [6:0] gen_q;
  logic [6:0] prev_q;
  logic [2:0] cnt_q;
  logic [7:0] gen_nxt;
  logic [7:0] expect_b;
  logic       match;

  // eight steps of x^7 + x^6 + 1, newest bit lands in bit 0
  function automatic logic [7:0] prbs_next8(input logic [6:0] seed);
    logic [6:0] s;
    logic [7:0] b;
    s = seed;
    b = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      b = {b[6:0], s[6] ^ s[5]};
      s = {s[5:0], s[6] ^ s[5]};
    end
    return b;
  endfunction : prbs_next8

  assign gen_nxt  = prbs_next8(gen_q);
  assign expect_b = prbs_next8(prev_q);
  assign match    = (chk_data == expect_b);
  assign chk_locked = (state_q == CHK_LOCK);

  // generator restarts from the seed whenever it is stopped
  always_ff @(posedge core_clk)
  begin
    if (rst || !gen_run)
    begin
      gen_q    <= `PRBS_SEED;
      gen_byte <= 8'h00;
      gen_busy <= 1'b0;
    end
    else
    begin
      gen_q    <= gen_nxt[6:0];
      gen_byte <= gen_nxt;
      gen_busy <= 1'b1;
    end
  end

  // self-sync: the last received byte predicts the next, so no seed alignment is needed
  always_ff @(posedge core_clk)
  begin
    if (rst || !chk_en)
    begin
      state_q  <= CHK_OFF;
      prev_q   <= 7'h00;
      cnt_q    <= 3'h0;
      chk_slip <= 1'b0;
      chk_gain <= 1'b0;
    end
    else
    begin
      chk_slip <= 1'b0;
      chk_gain <= 1'b0;
      if (chk_valid)
        prev_q <= chk_data[6:0];
      case (state_q)
        CHK_OFF:
          state_q <= CHK_HUNT;
        CHK_HUNT:
          if (chk_valid)
          begin
            cnt_q <= match ? cnt_q + 3'h1 : 3'h0;
            if (match && cnt_q == `LOCK_MATCHES - 3'h1)
            begin
              state_q  <= CHK_LOCK;
              chk_gain <= 1'b1;
            end
          end
        CHK_LOCK:
          if (chk_valid && !match)
          begin
            state_q  <= CHK_HUNT;
            cnt_q    <= 3'h0;
            chk_slip <= 1'b1;
          end
        default:
          state_q <= CHK_OFF;
      endcase
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  property p_chk_off;
    !chk_en |=> !chk_locked && !chk_slip;
  endproperty
  a_chk_off: assert property (p_chk_off) else $error("checker active while disabled");

  property p_chk_slip;
    chk_en && chk_locked && chk_valid && !match |=> chk_slip && !chk_locked;
  endproperty
  a_chk_slip: assert property (p_chk_slip) else $error("mismatch did not drop lock");
endmodule : prbs_engine
`default_nettype wire

// [logic/phy_bist_loopback_control.sv]
// self-test and loopback control: registers, loop steering and error tally
`include "phy_bist_map.svh"
`default_nettype none

module phy_bist_loopback_control
(
  input  wire logic                      core_clk,
  input  wire logic                      rst,
  input  wire logic [4:0]                reg_addr,
  input  wire logic [15:0]               reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output var  logic [15:0]               reg_rdata,
  input  wire logic                      speed_gig,
  input  wire logic [7:0]                mac_tx_data,
  input  wire logic                      mac_tx_valid,
  input  wire logic [7:0]                line_rx_data,
  input  wire logic                      line_rx_valid,
  input  wire logic                      line_rx_err,
  output var  logic [7:0]                line_tx_data,
  output var  logic                      line_tx_valid,
  output var  logic [7:0]                mac_rx_data,
  output var  logic                      mac_rx_valid,
  output var  phy_bist_pkg::loop_point_t loop_point,
  output var  logic                      irq
);
  import phy_bist_pkg::*;

  // ------------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------------
  logic [15:0]           tally_q;
  logic [15:0]           tally_d;
  logic [15:0]           ctrl_q;
  logic [15:0]           status_word;
  logic                  loss_q;
  logic [`IRQ_BITS-1:0]  irq_stat_q;
  logic [`IRQ_BITS-1:0]  irq_mask_q;
  logic [`IRQ_BITS-1:0]  irq_evt;
  logic [3:0]            wr_sel;
  logic                  tally_wr;
  logic                  ctrl_wr;
  logic                  istat_wr;
  logic                  imask_wr;
  logic                  stat_rd;
  logic                  tally_inc;
  logic                  gen_run;
  logic                  gen_busy;
  logic [7:0]            gen_byte;
  logic                  chk_en;
  logic                  chk_valid;
  logic [7:0]            chk_data;
  logic                  chk_locked;
  logic                  chk_slip;
  logic                  chk_gain;
  logic [7:0]            src_data;
  logic                  src_valid;
  logic                  mac_side;
  logic                  fwd_rx;
  logic                  fwd_tx;

  // ------------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------------
  function automatic logic hit(input logic [4:0] a, input logic [4:0] want);
    return a == want;
  endfunction : hit

  // coding-layer field wins; the one-hot select counts only while it is zero
  function automatic loop_point_t decode_point(input logic [1:0] pcs,
                                               input logic [3:0] sel,
                                               input logic       gig);
    loop_point_t p;
    p = LP_NONE;
    if (gig && pcs[0])
      p = LP_PRE_GDSP;
    else if (!gig && pcs == 2'b01)
      p = LP_PRE_SCR;
    else if (!gig && pcs == 2'b10)
      p = LP_POST_SCR;
    else if (!gig && pcs == 2'b11)
      p = LP_POST_MLT3;
    else if (pcs == 2'b00)
    begin
      case (sel)
        LOOP_DIGITAL:
          p = LP_DIGITAL;
        LOOP_ANALOG:
          p = LP_ANALOG;
        LOOP_EXTERNAL:
          p = LP_EXTERNAL;
        LOOP_REVERSE:
          p = LP_REVERSE;
        default:
          p = LP_NONE;
      endcase
    end
    return p;
  endfunction : decode_point

  // ------------------------------------------------------------------
  // register strobes
  // ------------------------------------------------------------------
  assign tally_wr = reg_wr && hit(reg_addr, `ADDR_RX_TALLY);
  assign ctrl_wr  = reg_wr && hit(reg_addr, `ADDR_LOOP_CTRL);
  assign istat_wr = reg_wr && hit(reg_addr, `ADDR_IRQ_STAT);
  assign imask_wr = reg_wr && hit(reg_addr, `ADDR_IRQ_MASK);
  assign stat_rd  = reg_rd && hit(reg_addr, `ADDR_GEN_STATUS);
  assign wr_sel   = reg_wdata[`LOOP_SEL_HI:`LOOP_SEL_LO];

  // ------------------------------------------------------------------
  // loop control register
  // ------------------------------------------------------------------
  // forwarding bits are judged against the select written in the same word,
  // so a single write can enter a mode and set its forwarding bit together
  always_ff @(posedge core_clk)
  begin
    if (rst)
      ctrl_q <= `CTRL_RESET;
    else if (ctrl_wr)
    begin
      ctrl_q[`GEN_EN_HI:`GEN_EN_LO]   <= reg_wdata[`GEN_EN_HI:`GEN_EN_LO];
      ctrl_q[`RSVD_RW_HI:`RSVD_RW_LO] <= reg_wdata[`RSVD_RW_HI:`RSVD_RW_LO];
      ctrl_q[`FWD_RX_BIT]  <= (wr_sel == LOOP_REVERSE) && reg_wdata[`FWD_RX_BIT];
      ctrl_q[`FWD_TX_BIT]  <= (wr_sel == LOOP_DIGITAL) && reg_wdata[`FWD_TX_BIT];
      ctrl_q[`LOOP_SEL_HI:`LOOP_SEL_LO] <= wr_sel;
      ctrl_q[`PCS_HI:`PCS_LO]           <= reg_wdata[`PCS_HI:`PCS_LO];
    end
  end

  assign fwd_rx  = ctrl_q[`FWD_RX_BIT];
  assign fwd_tx  = ctrl_q[`FWD_TX_BIT];
  // only the all-ones code runs; the other codes are unused and act as stop
  assign gen_run = (ctrl_q[`GEN_EN_HI:`GEN_EN_LO] == `GEN_EN_RUN);

  // loop point is registered so the signal chain sees a clean change
  always_ff @(posedge core_clk)
  begin
    if (rst)
      loop_point <= LP_NONE;
    else
      loop_point <= decode_point(ctrl_q[`PCS_HI:`PCS_LO],
                                 ctrl_q[`LOOP_SEL_HI:`LOOP_SEL_LO], speed_gig);
  end

  // ------------------------------------------------------------------
  // data steering
  // ------------------------------------------------------------------
  // digital and coding-layer loops turn transmit data back near the mac
  assign mac_side  = (loop_point == LP_DIGITAL) || (loop_point == LP_PRE_SCR) ||
                     (loop_point == LP_POST_SCR) || (loop_point == LP_POST_MLT3) ||
                     (loop_point == LP_PRE_GDSP);
  // the generator takes over the transmit source while it runs
  assign src_data  = gen_busy ? gen_byte : mac_tx_data;
  assign src_valid = gen_busy || mac_tx_valid;
  // the checker watches whatever comes back towards the mac
  assign chk_en    = gen_run && (loop_point != LP_NONE);
  assign chk_data  = mac_side ? src_data : line_rx_data;
  assign chk_valid = mac_side ? src_valid : line_rx_valid;

  // medium side transmit path
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      line_tx_data  <= 8'h00;
      line_tx_valid <= 1'b0;
    end
    else if (loop_point == LP_REVERSE)
    begin
      line_tx_data  <= line_rx_data;
      line_tx_valid <= line_rx_valid;
    end
    else if (mac_side)
    begin
      line_tx_data  <= src_data;
      line_tx_valid <= src_valid && fwd_tx;
    end
    else
    begin
      line_tx_data  <= src_data;
      line_tx_valid <= src_valid;
    end
  end

  // mac side receive path
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      mac_rx_data  <= 8'h00;
      mac_rx_valid <= 1'b0;
    end
    else if (mac_side)
    begin
      mac_rx_data  <= src_data;
      mac_rx_valid <= src_valid;
    end
    else if (loop_point == LP_REVERSE)
    begin
      mac_rx_data  <= line_rx_data;
      mac_rx_valid <= line_rx_valid && fwd_rx;
    end
    else
    begin
      mac_rx_data  <= line_rx_data;
      mac_rx_valid <= line_rx_valid;
    end
  end

  // ------------------------------------------------------------------
  // pattern generator and checker
  // ------------------------------------------------------------------
  prbs_engine u_prbs
  (
    .core_clk   (core_clk),
    .rst        (rst),
    .gen_run    (gen_run),
    .gen_byte   (gen_byte),
    .gen_busy   (gen_busy),
    .chk_en     (chk_en),
    .chk_valid  (chk_valid),
    .chk_data   (chk_data),
    .chk_locked (chk_locked),
    .chk_slip   (chk_slip),
    .chk_gain   (chk_gain)
  );

  // ------------------------------------------------------------------
  // receive error tally
  // ------------------------------------------------------------------
  // a line error and a checker slip in one cycle count as one event
  assign tally_inc = (line_rx_valid && line_rx_err) || chk_slip;

  // clear first, then count, so an event in the clearing cycle survives
  always_comb
  begin
    tally_d = tally_q;
    if (tally_wr)
      tally_d = tally_q & ~reg_wdata;
    if (tally_inc && tally_d != `TALLY_MAX)
      tally_d = tally_d + `TALLY_ONE;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      tally_q <= `TALLY_RESET;
    else
      tally_q <= tally_d;
  end

  // ------------------------------------------------------------------
  // status word and sync loss latch
  // ------------------------------------------------------------------
  // a slip in the reading cycle wins, so the next read still reports it
  always_ff @(posedge core_clk)
  begin
    if (rst)
      loss_q <= 1'b0;
    else if (chk_slip)
      loss_q <= 1'b1;
    else if (stat_rd)
      loss_q <= 1'b0;
  end

  // power bit reads as its reset value; that state lives elsewhere
  always_comb
  begin
    status_word            = `STATUS_RESET;
    status_word[`LOCK_BIT] = chk_locked;
    status_word[`LOSS_BIT] = loss_q;
    status_word[`BUSY_BIT] = gen_busy;
  end

  // ------------------------------------------------------------------
  // interrupts
  // ------------------------------------------------------------------
  assign irq_evt[`IRQ_SLIP] = chk_slip;
  assign irq_evt[`IRQ_GAIN] = chk_gain;
  assign irq_evt[`IRQ_SAT]  = tally_inc && (tally_q == `TALLY_MAX);

  // sticky bits, write one to clear, a new event beats the clear
  for (genvar gi = 0; gi < `IRQ_BITS; gi++)
  begin : g_irq
    always_ff @(posedge core_clk)
    begin
      if (rst)
        irq_stat_q[gi] <= 1'b0;
      else if (irq_evt[gi])
        irq_stat_q[gi] <= 1'b1;
      else if (istat_wr && reg_wdata[gi])
        irq_stat_q[gi] <= 1'b0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      irq_mask_q <= '0;
    else if (imask_wr)
      irq_mask_q <= reg_wdata[`IRQ_BITS-1:0];
  end

  // one cycle behind the status bits, traded for a flop-driven pin
  always_ff @(posedge core_clk)
  begin
    if (rst)
      irq <= 1'b0;
    else
      irq <= |(irq_stat_q & irq_mask_q);
  end

  // ------------------------------------------------------------------
  // read port
  // ------------------------------------------------------------------
  // data stand only in the cycle after the strobe; unmapped reads give zero
  always_ff @(posedge core_clk)
  begin
    if (rst || !reg_rd)
      reg_rdata <= `READ_IDLE;
    else
      case (reg_addr)
        `ADDR_RX_TALLY:
          reg_rdata <= tally_q;
        `ADDR_LOOP_CTRL:
          reg_rdata <= ctrl_q;
        `ADDR_GEN_STATUS:
          reg_rdata <= status_word;
        `ADDR_IRQ_STAT:
          reg_rdata <= {13'h0000, irq_stat_q};
        `ADDR_IRQ_MASK:
          reg_rdata <= {13'h0000, irq_mask_q};
        default:
          reg_rdata <= `READ_IDLE;
      endcase
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  sequence s_loss_pending;
    loss_q && !chk_slip;
  endsequence

  sequence s_status_read;
    stat_rd ##0 s_loss_pending;
  endsequence

  property p_tally_w1c;
    tally_wr && !tally_inc |=> tally_q == ($past(tally_q) & ~$past(reg_wdata));
  endproperty
  a_tally_w1c: assert property (p_tally_w1c) else $error("tally clear wrong");

  property p_tally_step;
    tally_inc && !tally_wr && tally_q != `TALLY_MAX |=> tally_q == $past(tally_q) + `TALLY_ONE;
  endproperty
  a_tally_step: assert property (p_tally_step) else $error("tally did not count");

  property p_tally_hold;
    tally_q == `TALLY_MAX && !tally_wr |=> tally_q == `TALLY_MAX;
  endproperty
  a_tally_hold: assert property (p_tally_hold) else $error("tally wrapped");

  property p_gen_run;
    gen_run |=> gen_busy;
  endproperty
  a_gen_run: assert property (p_gen_run) else $error("generator not started");

  property p_gen_busy;
    !gen_run |=> !gen_busy;
  endproperty
  a_gen_busy: assert property (p_gen_busy) else $error("busy without enable");

  property p_fwd_rx;
    fwd_rx |-> ctrl_q[`LOOP_SEL_HI:`LOOP_SEL_LO] == LOOP_REVERSE;
  endproperty
  a_fwd_rx: assert property (p_fwd_rx) else $error("rx forward outside reverse");

  property p_fwd_tx;
    fwd_tx |-> ctrl_q[`LOOP_SEL_HI:`LOOP_SEL_LO] == LOOP_DIGITAL;
  endproperty
  a_fwd_tx: assert property (p_fwd_tx) else $error("tx forward outside mac loop");

  property p_rev_hold;
    loop_point == LP_REVERSE && !fwd_rx |=> !mac_rx_valid;
  endproperty
  a_rev_hold: assert property (p_rev_hold) else $error("rx reached mac");

  property p_rev_pass;
    loop_point == LP_REVERSE && fwd_rx && line_rx_valid
      |=> mac_rx_valid && mac_rx_data == $past(line_rx_data);
  endproperty
  a_rev_pass: assert property (p_rev_pass) else $error("rx not forwarded");

  property p_mac_hold;
    mac_side && !fwd_tx |=> !line_tx_valid;
  endproperty
  a_mac_hold: assert property (p_mac_hold) else $error("tx reached medium");

  property p_mac_pass;
    mac_side && fwd_tx && src_valid |=> line_tx_valid && line_tx_data == $past(src_data);
  endproperty
  a_mac_pass: assert property (p_mac_pass) else $error("tx not forwarded");

  property p_point_rev;
    ctrl_q[`PCS_HI:`PCS_LO] == 2'b00 && ctrl_q[`LOOP_SEL_HI:`LOOP_SEL_LO] == LOOP_REVERSE
      |=> loop_point == LP_REVERSE;
  endproperty
  a_point_rev: assert property (p_point_rev) else $error("reverse not selected");

  property p_point_100;
    !speed_gig && ctrl_q[`PCS_HI:`PCS_LO] == 2'b11 |=> loop_point == LP_POST_MLT3;
  endproperty
  a_point_100: assert property (p_point_100) else $error("100M loop point wrong");

  property p_point_gig;
    speed_gig && ctrl_q[`PCS_LO] |=> loop_point == LP_PRE_GDSP;
  endproperty
  a_point_gig: assert property (p_point_gig) else $error("1G loop point wrong");

  property p_lock_read;
    stat_rd |=> reg_rdata[`LOCK_BIT] == $past(chk_locked);
  endproperty
  a_lock_read: assert property (p_lock_read) else $error("lock bit misread");

  property p_loss_set;
    chk_slip |=> loss_q ##0 (!stat_rd || chk_slip || loss_q);
  endproperty
  a_loss_set: assert property (p_loss_set) else $error("sync loss not latched");

  property p_loss_clear;
    s_status_read |=> !loss_q && reg_rdata[`LOSS_BIT];
  endproperty
  a_loss_clear: assert property (p_loss_clear) else $error("sync loss read clear");
endmodule : phy_bist_loopback_control
`default_nettype wire

// [verif/line_partner.sv]
// medium model: echoes the transmit stream or plays bench bytes
`default_nettype none
module line_partner
(
  input  wire logic       core_clk,
  input  wire logic       echo,
  input  wire logic       spoil,
  input  wire logic       play_valid,
  input  wire logic [7:0] play_data,
  input  wire logic [7:0] line_tx_data,
  input  wire logic       line_tx_valid,
  output var  logic [7:0] line_rx_data,
  output var  logic       line_rx_valid,
  output var  logic       line_rx_err
);
  timeunit 1ns;
  timeprecision 1ps;
  logic v;
  assign v = echo ? line_tx_valid : play_valid;
  initial line_rx_data = 8'h00;
  // one cycle of wire; idle shows the inverse of the last byte, not a stale copy
  always @(posedge core_clk)
  begin
    line_rx_valid <= v;
    line_rx_err <= v && spoil && !echo;
    line_rx_data <= !v ? ~line_rx_data : echo ? line_tx_data ^ {8{spoil}} : play_data;
  end
endmodule : line_partner
`default_nettype wire

// [verif/test_phy_bist_loopback_control.sv]
// self-checking bench for the self-test and loopback control block
`default_nettype none
module test_phy_bist_loopback_control;
  timeunit 1ns;
  timeprecision 1ps;
  import phy_bist_pkg::*;
  logic        core_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, speed_gig = 0, irq;
  logic        mac_tx_valid = 0, echo = 0, spoil = 0, play_valid = 0;
  logic        line_rx_valid, line_rx_err, line_tx_valid, mac_rx_valid;
  logic [4:0]  reg_addr = 5'h00;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, rv;
  logic [7:0]  mac_tx_data = 8'h00, line_rx_data, line_tx_data, mac_rx_data;
  loop_point_t loop_point;
  int          n_mismatch = 0, checks_done = 0;
  // 100 MHz core clock
  always #5 core_clk = ~core_clk;
  phy_bist_loopback_control i_dut (.*);
  line_partner i_medium (.*, .play_data(mac_tx_data));
  task automatic chk(input logic [15:0] got, exp);
    checks_done++;
    n_mismatch += int'(got !== exp);
    if (got !== exp)
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [15:0] m, e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
    chk(rv & m, e);
  endtask : rd
  task automatic lp(input logic g, input logic [15:0] w, input logic [3:0] e);
    wr(5'h16, w);
    speed_gig <= g;
    @(posedge core_clk);
    #1 chk({12'h000, loop_point}, {12'h000, e});
  endtask : lp
  task automatic pass(input logic [15:0] c, el, em, input logic m);
    wr(5'h16, c);
    @(posedge core_clk);
    mac_tx_valid <= m;
    play_valid <= !m;
    mac_tx_data <= c[7:0];
    @(posedge core_clk);
    mac_tx_valid <= 1'b0;
    play_valid <= 1'b0;
    if (!m)
      @(posedge core_clk);
    #1 chk({7'h00, line_tx_valid, line_tx_data & {8{line_tx_valid}}}, el);
    chk({7'h00, mac_rx_valid, mac_rx_data & {8{mac_rx_valid}}}, em);
  endtask : pass
  task automatic end_sim;
    $display("checks_done %0d n_mismatch %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  // main sequence; every wait is a fixed count or a bounded poll
  initial
  begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    rd(5'h15, 16'hffff, 16'h0000);
    rd(5'h17, 16'hffff, 16'h0040);
    rd(5'h03, 16'hffff, 16'h0000);
    wr(5'h16, 16'h0fc8);
    rd(5'h16, 16'hffff, 16'h0308);
    for (int i = 0; i < 4; i++)
      lp(1'b0, 16'h0004 << i, 4'(i + 1));
    for (int j = 1; j < 4; j++)
    begin
      lp(1'b0, 16'(j), 4'(j + 4));
      lp(1'b1, 16'(j), j[0] ? 4'h8 : 4'h0);
    end
    wr(5'h16, 16'h0000);
    pass(16'h0020, 16'h0120, 16'h0000, 1'b0);
    pass(16'h00a0, 16'h01a0, 16'h01a0, 1'b0);
    pass(16'h0004, 16'h0000, 16'h0104, 1'b1);
    pass(16'h0044, 16'h0144, 16'h0144, 1'b1);
    @(posedge core_clk);
    spoil <= 1'b1;
    play_valid <= 1'b1;
    repeat (3) @(posedge core_clk);
    spoil <= 1'b0;
    play_valid <= 1'b0;
    wr(5'h15, 16'h0001);
    rd(5'h15, 16'hffff, 16'h0002);
    wr(5'h15, 16'hffff);
    wr(5'h1d, 16'h0001);
    echo <= 1'b1;
    wr(5'h16, 16'hf010);
    for (int k = 0; k < 40 && !rv[11]; k++)
      rd(5'h17, 16'h0040, 16'h0040);
    // a poll that never sees lock counts as a mismatch
    if (!rv[11])
      n_mismatch++;
    rd(5'h17, 16'h0e40, 16'h0a40);
    @(posedge core_clk);
    spoil <= 1'b1;
    @(posedge core_clk);
    spoil <= 1'b0;
    repeat (6) @(posedge core_clk);
    #1 chk({15'h0000, irq}, 16'h0001);
    rd(5'h17, 16'h0400, 16'h0400);
    rd(5'h17, 16'h0400, 16'h0000);
    rd(5'h15, 16'hffff, 16'h0001);
    wr(5'h1c, 16'h0001);
    rd(5'h1c, 16'h0007, 16'h0002);
    chk({15'h0000, irq}, 16'h0000);
    // stopping the generator drops busy and lock
    wr(5'h16, 16'h0000);
    rd(5'h17, 16'h0a00, 16'h0000);
    // run the tally into its ceiling with a long error burst
    echo <= 1'b0;
    spoil <= 1'b1;
    play_valid <= 1'b1;
    repeat (65540) @(posedge core_clk);
    spoil <= 1'b0;
    play_valid <= 1'b0;
    rd(5'h15, 16'hffff, 16'hffff);
    rd(5'h1c, 16'h0004, 16'h0004);
    end_sim();
  end
endmodule : test_phy_bist_loopback_control
`default_nettype wire
